// ==== rtl/gpio_port_pkg.sv ====
package gpio_port_pkg;
  localparam int PORT_WIDTH = 8;
  localparam int ADDR_WIDTH = 5;
  // Register byte offsets
  localparam logic [4:0] OFF_PIN_DATA = 5'h00;
  localparam logic [4:0] OFF_DIRECTION = 5'h04;
  localparam logic [4:0] OFF_OUTPUT_LATCH = 5'h08;
  localparam logic [4:0] OFF_OPEN_DRAIN = 5'h0c;
  localparam logic [4:0] OFF_SLEW_LIMIT = 5'h10;
  localparam logic [4:0] OFF_THRESHOLD = 5'h14;
  localparam logic [4:0] OFF_ANALOG_SELECT = 5'h18;
  // Reset values
  localparam logic [7:0] RST_DIRECTION = 8'hff;
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_OPEN_DRAIN = 8'h00;
  localparam logic [7:0] RST_SLEW = 8'h00;
  localparam logic [7:0] RST_THRESHOLD = 8'h00;
  localparam logic [7:0] RST_ANALOG = 8'hff;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

// ==== rtl/pin_sync.sv ====
`timescale 1ns/1ns
module pin_sync
  import gpio_port_pkg::*;
#(
  parameter int WIDTH = PORT_WIDTH
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_reg;

  // Two-flop synchroniser, first stage read only by the second
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1_reg <= '0;
      sync_out <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end
endmodule

// ==== rtl/pad_driver.sv ====
`timescale 1ns/1ns
module pad_driver
  import gpio_port_pkg::*;
#(
  parameter int WIDTH = PORT_WIDTH
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] direction_in,
  input wire logic [WIDTH-1:0] latch_in,
  input wire logic [WIDTH-1:0] open_drain_in,
  output logic [WIDTH-1:0] pad_out,
  output logic [WIDTH-1:0] pad_oe_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          pad_out[i] <= 1'b0;
          pad_oe_out[i] <= 1'b0;
        end else begin
          pad_out[i] <= open_drain_in[i] ? 1'b0 : latch_in[i];
          pad_oe_out[i] <= !direction_in[i] && !(open_drain_in[i] && latch_in[i]);
        end
      end
    end
  endgenerate
endmodule

// ==== rtl/gpio_port.sv ====
// Chosen here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ns
// Behaviour
// - Eight pins, each input or output
// - Direction one turns driver off
// - Direction zero drives latch bit
// - Reads pins, writes go to latch
// - Port writes load the whole byte into the latch
// - Direction governs drivers, even analog
// - Open-drain sinks only, else push-pull
// - Slew bit limits edge rate
// - Threshold bit picks CMOS or TTL
// - Analog pins read zero digitally
// - Analog select leaves outputs alone
// - Analog select resets to analog
module gpio_port
  import gpio_port_pkg::*;
#(
  parameter int WIDTH = PORT_WIDTH
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [ADDR_WIDTH-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic [WIDTH-1:0] pad_in,
  output logic [WIDTH-1:0] pad_out,
  output logic [WIDTH-1:0] pad_oe_out,
  output logic [WIDTH-1:0] slew_limit_out,
  output logic [WIDTH-1:0] ttl_threshold_out,
  output logic [WIDTH-1:0] analog_enable_out,
  output logic [WIDTH-1:0] digital_in_out
);
  logic rst_meta_reg;
  logic rst_n_reg;
  logic [WIDTH-1:0] pin_sync;
  logic [WIDTH-1:0] pin_digital;
  logic [WIDTH-1:0] direction_reg;
  logic [WIDTH-1:0] latch_reg;
  logic [WIDTH-1:0] latch_next;
  logic [WIDTH-1:0] open_drain_reg;
  logic [WIDTH-1:0] slew_reg;
  logic [WIDTH-1:0] threshold_reg;
  logic [WIDTH-1:0] analog_reg;
  logic [31:0] read_next;
  logic req;
  logic wr_lane0;

  ////////////////////////////////////////////////////////////////////
  // Reset release
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Input path
  // synchronise pin samples
  pin_sync #(.WIDTH(WIDTH)) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_reg),
    .async_in(pad_in),
    .sync_out(pin_sync)
  );

  assign pin_digital = pin_sync & ~analog_reg;

  // Threshold choice lives in the pad cell; selection drives it out
  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      digital_in_out <= '0;
      analog_enable_out <= RST_ANALOG;
      ttl_threshold_out <= RST_THRESHOLD;
      slew_limit_out <= RST_SLEW;
    end else begin
      digital_in_out <= pin_digital;
      analog_enable_out <= analog_reg;
      ttl_threshold_out <= threshold_reg;
      slew_limit_out <= slew_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bus slave: answers one cycle after request, ack drops next cycle
  assign req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr_lane0 = req && wb_we_in && wb_sel_in[0];

  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= req;
    end
  end

  always_comb begin
    latch_next = latch_reg;
    if (wr_lane0 && wb_adr_in == OFF_PIN_DATA) begin
      latch_next = wb_dat_in[WIDTH-1:0];
    end else if (wr_lane0 && wb_adr_in == OFF_OUTPUT_LATCH) begin
      latch_next = wb_dat_in[WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      latch_reg <= RST_LATCH;
    end else begin
      latch_reg <= latch_next;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      direction_reg <= RST_DIRECTION;
    end else if (wr_lane0 && wb_adr_in == OFF_DIRECTION) begin
      direction_reg <= wb_dat_in[WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      open_drain_reg <= RST_OPEN_DRAIN;
    end else if (wr_lane0 && wb_adr_in == OFF_OPEN_DRAIN) begin
      open_drain_reg <= wb_dat_in[WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      slew_reg <= RST_SLEW;
    end else if (wr_lane0 && wb_adr_in == OFF_SLEW_LIMIT) begin
      slew_reg <= wb_dat_in[WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      threshold_reg <= RST_THRESHOLD;
    end else if (wr_lane0 && wb_adr_in == OFF_THRESHOLD) begin
      threshold_reg <= wb_dat_in[WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      analog_reg <= RST_ANALOG;
    end else if (wr_lane0 && wb_adr_in == OFF_ANALOG_SELECT) begin
      analog_reg <= wb_dat_in[WIDTH-1:0];
    end
  end

  always_comb begin
    read_next = UNMAPPED_READ;
    unique case (wb_adr_in)
      OFF_PIN_DATA: read_next[WIDTH-1:0] = pin_digital;
      OFF_DIRECTION: read_next[WIDTH-1:0] = direction_reg;
      OFF_OUTPUT_LATCH: read_next[WIDTH-1:0] = latch_reg;
      OFF_OPEN_DRAIN: read_next[WIDTH-1:0] = open_drain_reg;
      OFF_SLEW_LIMIT: read_next[WIDTH-1:0] = slew_reg;
      OFF_THRESHOLD: read_next[WIDTH-1:0] = threshold_reg;
      OFF_ANALOG_SELECT: read_next[WIDTH-1:0] = analog_reg;
      default: read_next = UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      wb_dat_out <= UNMAPPED_READ;
    end else if (req && !wb_we_in) begin
      wb_dat_out <= read_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Output path
  // one driver slice per pin
  pad_driver #(.WIDTH(WIDTH)) u_drv (
    .clk_in(clk_in),
    .rst_n_in(rst_n_reg),
    .direction_in(direction_reg),
    .latch_in(latch_reg),
    .open_drain_in(open_drain_reg),
    .pad_out(pad_out),
    .pad_oe_out(pad_oe_out)
  );

  ////////////////////////////////////////////////////////////////////
  // Checks
  // ack lasts one cycle
  a_ack_single: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    wb_ack_out |=> !wb_ack_out)
    else $error("ack held two cycles");

  a_ack_follows: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    req |=> wb_ack_out)
    else $error("ack missing");

  a_latch_write: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    (wr_lane0 && wb_adr_in == OFF_PIN_DATA) |=> latch_reg == $past(wb_dat_in[WIDTH-1:0]))
    else $error("port write missed latch");

  a_analog_zero: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    (digital_in_out & analog_enable_out) == '0)
    else $error("analog pin read one");

  a_input_hiz: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    ##1 ((pad_oe_out & $past(direction_reg)) == '0))
    else $error("input pin driven");

  a_output_drive: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    ##1 ((pad_out & ~$past(open_drain_reg)) == ($past(latch_reg) & ~$past(open_drain_reg))))
    else $error("output not latch");

  a_od_sink: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    ##1 ((pad_oe_out & $past(open_drain_reg) & $past(latch_reg)) == '0))
    else $error("open drain sourced");

  a_sync_delay: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    ##3 (digital_in_out == ($past(pad_in, 3) & ~$past(analog_reg, 1))))
    else $error("sync latency wrong");

  a_slew_follow: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    ##1 (slew_limit_out == $past(slew_reg)))
    else $error("slew out stale");

  a_thresh_follow: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    ##1 (ttl_threshold_out == $past(threshold_reg)))
    else $error("threshold stale");

  a_latch_alias: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    (wr_lane0 && wb_adr_in == OFF_OUTPUT_LATCH) |=> latch_reg == $past(wb_dat_in[WIDTH-1:0]))
    else $error("latch write missed");

  a_latch_hold: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    !(wr_lane0 && (wb_adr_in == OFF_PIN_DATA || wb_adr_in == OFF_OUTPUT_LATCH)) |=> $stable(latch_reg))
    else $error("latch changed unasked");

  a_lane_ignored: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    (req && wb_we_in && !wb_sel_in[0]) |=> ($stable(latch_reg) && $stable(direction_reg)))
    else $error("masked write landed");

  a_read_pins: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    (req && !wb_we_in && wb_adr_in == OFF_PIN_DATA) |=> wb_dat_out[WIDTH-1:0] == $past(pin_sync & ~analog_reg))
    else $error("pin read wrong");

  a_read_upper: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    wb_ack_out |-> (wb_dat_out >> WIDTH) == '0)
    else $error("upper read bits set");

  a_read_hold: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    !(req && !wb_we_in) |=> $stable(wb_dat_out))
    else $error("read data moved");

  a_analog_read: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    (req && !wb_we_in && wb_adr_in == OFF_PIN_DATA) |=> (wb_dat_out[WIDTH-1:0] & $past(analog_reg)) == '0)
    else $error("analog bit read one");

  a_dir_write: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    (wr_lane0 && wb_adr_in == OFF_DIRECTION) |=> direction_reg == $past(wb_dat_in[WIDTH-1:0]))
    else $error("direction write missed");

  a_od_write: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    (wr_lane0 && wb_adr_in == OFF_OPEN_DRAIN) |=> open_drain_reg == $past(wb_dat_in[WIDTH-1:0]))
    else $error("open drain write missed");

  a_slew_write: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    (wr_lane0 && wb_adr_in == OFF_SLEW_LIMIT) |=> slew_reg == $past(wb_dat_in[WIDTH-1:0]))
    else $error("slew write missed");

  a_thresh_write: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    (wr_lane0 && wb_adr_in == OFF_THRESHOLD) |=> threshold_reg == $past(wb_dat_in[WIDTH-1:0]))
    else $error("threshold write missed");

  a_analog_write: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    (wr_lane0 && wb_adr_in == OFF_ANALOG_SELECT) |=> analog_reg == $past(wb_dat_in[WIDTH-1:0]))
    else $error("analog write missed");

  a_analog_follow: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    ##1 (analog_enable_out == $past(analog_reg)))
    else $error("analog out stale");

  a_analog_drive: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    ##1 (pad_oe_out == (~$past(direction_reg) & ~($past(open_drain_reg) & $past(latch_reg)))))
    else $error("enable depends on analog");

  a_pushpull_src: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    ##1 ((pad_oe_out & ~$past(open_drain_reg)) == (~$past(direction_reg) & ~$past(open_drain_reg))))
    else $error("push pull not driven");

  a_od_low: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    ##1 ((pad_out & $past(open_drain_reg)) == '0))
    else $error("open drain drove high");

  a_dir_governs: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    ##1 ((pad_oe_out & $past(direction_reg) & $past(analog_reg)) == '0))
    else $error("analog input driven");
endmodule

// ==== verif/pin_load_model.sv ====
`timescale 1ns/1ns
module pin_load_model (
  input wire logic [7:0] pad_out_in,
  input wire logic [7:0] pad_oe_in,
  input wire logic [7:0] ext_val_in,
  input wire logic [7:0] ext_en_in,
  output logic [7:0] level_out
);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      level_out[i] = pad_oe_in[i] ? pad_out_in[i] : (ext_en_in[i] ? ext_val_in[i] : 1'b1);
    end
  end
endmodule

// ==== verif/gpio_port_tb_top.sv ====
`timescale 1ns/1ns
module gpio_port_tb_top
  import gpio_port_pkg::*;
;
  logic clk_in, reset_n_in, cyc, stb, we, ack;
  logic [4:0] adr;
  logic [3:0] sel, lane;
  logic [31:0] wdat, rdat, rd;
  logic [7:0] pad_out, pad_oe, slew, ttl, ana, dig, level, ext_val, ext_en;
  int bad_count, checks_done;

  gpio_port i_gpio_port (.clk_in(clk_in), .reset_n_in(reset_n_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .pad_in(level), .pad_out(pad_out),
    .pad_oe_out(pad_oe), .slew_limit_out(slew), .ttl_threshold_out(ttl),
    .analog_enable_out(ana), .digital_in_out(dig));
  pin_load_model i_pin_load_model (.pad_out_in(pad_out), .pad_oe_in(pad_oe),
    .ext_val_in(ext_val), .ext_en_in(ext_en), .level_out(level));

  ////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits for ack under a bound; read data taken at the ack edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= lane;
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      bad_count++;
      end_of_test();
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [4:0] offs [7] = '{OFF_PIN_DATA, OFF_DIRECTION, OFF_OUTPUT_LATCH, OFF_OPEN_DRAIN,
      OFF_SLEW_LIMIT, OFF_THRESHOLD, OFF_ANALOG_SELECT};
    logic [7:0] exp [7] = '{8'h00, RST_DIRECTION, RST_LATCH, RST_OPEN_DRAIN, RST_SLEW,
      RST_THRESHOLD, RST_ANALOG};
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, offs[i], 8'h00);
      chk(rd, {24'h0, exp[i]});
    end
    chk(ana, 8'hff);
    chk(pad_oe, 8'h00);
  endtask

  task automatic t_analog();
    chk(dig, 8'h00);
    // software clears analog before digital use
    bus(1'b1, OFF_ANALOG_SELECT, 8'h00);
    repeat (4) @(posedge clk_in);
    chk(dig, 8'ha5);
    bus(1'b0, OFF_PIN_DATA, 8'h00);
    chk(rd, 32'h0000_00a5);
  endtask

  task automatic t_drive();
    ext_en <= 8'h00;
    bus(1'b1, OFF_PIN_DATA, 8'h3c);
    bus(1'b0, OFF_OUTPUT_LATCH, 8'h00);
    chk(rd, 32'h0000_003c);
    chk(pad_oe, 8'h00);
    repeat (4) @(posedge clk_in);
    bus(1'b0, OFF_PIN_DATA, 8'h00);
    chk(rd, 32'h0000_00ff);
    bus(1'b1, OFF_DIRECTION, 8'h00);
    repeat (2) @(posedge clk_in);
    chk({pad_oe, pad_out}, 16'hff3c);
    bus(1'b1, OFF_ANALOG_SELECT, 8'hff);
    repeat (4) @(posedge clk_in);
    chk({pad_oe, pad_out}, 16'hff3c);
    bus(1'b0, OFF_PIN_DATA, 8'h00);
    chk(rd, 32'h0);
    // analog left on driven pins only for this check
    bus(1'b1, OFF_ANALOG_SELECT, 8'h00);
  endtask

  task automatic t_open_drain();
    bus(1'b1, OFF_OPEN_DRAIN, 8'hff);
    repeat (2) @(posedge clk_in);
    chk({pad_oe, pad_out}, 16'hc300);
    repeat (4) @(posedge clk_in);
    bus(1'b0, OFF_PIN_DATA, 8'h00);
    chk(rd, 32'h0000_003c);
  endtask

  task automatic t_controls();
    bus(1'b1, OFF_SLEW_LIMIT, 8'h5a);
    // threshold changed with no pin activity
    bus(1'b1, OFF_THRESHOLD, 8'ha5);
    repeat (2) @(posedge clk_in);
    chk(slew, 8'h5a);
    chk(ttl, 8'ha5);
    bus(1'b1, 5'h1c, 8'hff);
    bus(1'b0, 5'h1c, 8'h00);
    chk(rd, UNMAPPED_READ);
    lane = 4'he;
    bus(1'b1, OFF_OUTPUT_LATCH, 8'hff);
    lane = 4'hf;
    bus(1'b0, OFF_OUTPUT_LATCH, 8'h00);
    chk(rd, 32'h0000_003c);
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  initial begin
    reset_n_in = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 5'h00;
    sel = 4'h0;
    lane = 4'hf;
    wdat = 32'h0;
    ext_val = 8'ha5;
    ext_en = 8'hff;
    bad_count = 0;
    checks_done = 0;
    repeat (16) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_reset();
    t_analog();
    t_drive();
    t_open_drain();
    t_controls();
    end_of_test();
  end
endmodule
